// ==== core/scl_cfg.svh ====
/*
  Constants for the sync command line encoder: counts, codes, field
  positions and reset values. Assumes inclusion by bare name, once.
*/
`ifndef SCL_CFG_SVH
`define SCL_CFG_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// System clock rate in MHz.
`define SCL_CLK_MHZ 25
// Transceiver reset recovery gap between the two start-up commands, in us.
`define SCL_RECOVER_US 5000
// Recovery gap in cycles, taken as a least time.
`define SCL_RECOVER_CYCLES (`SCL_RECOVER_US * `SCL_CLK_MHZ)

// ----------------------------------------------------------------------
// Command framing
// ----------------------------------------------------------------------
// Idle ones needed after a stop bit before a new start bit.
`define SCL_IDLE_MIN 3'h5
// Saturation value of the idle ones counter.
`define SCL_ONES_SAT 3'h7
// Bits still to go after the start bit: four data bits and the stop bit.
`define SCL_FRAME_REST 3'h5
// Idle level of the line.
`define SCL_LINE_IDLE 1'h1
// Manchester pair shown while idle and in reset.
`define SCL_PAIR_IDLE 2'h2
// Default command codes, shared with the decoder.
`define SCL_CMD_CLK_RESET 4'h1
`define SCL_CMD_TRG_START 4'h2

// ----------------------------------------------------------------------
// Trigger link
// ----------------------------------------------------------------------
// Last 40 ns phase of a 160 ns slot.
`define SCL_SLOT_LAST 2'h3
// Launch phase so the start bit leaves the encoder at slot phase 0.
`define SCL_LAUNCH_PHASE 2'h2
// Word type codes in bits 15:12.
`define SCL_WORD_TIME 4'h4
`define SCL_WORD_STROBE 4'h9
// Word sent while the link is not started.
`define SCL_IDLE_WORD 16'h0000
// Master time word carries time bits 13:2.
`define SCL_TIME_HI 13
`define SCL_TIME_LO 2

`endif

// ==== core/scl_pkg.sv ====
/*
  Types of the sync command line encoder. Assumes scl_cfg.svh is used
  by the design files for all numbers.
*/
package scl_pkg;

  // ----------------------------------------------------------------------
  // Start-up sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_BOOT = 3'h0,
    SEQ_PHASE = 3'h1,
    SEQ_RECOVER = 3'h2,
    SEQ_ARMED = 3'h3,
    SEQ_DELAY = 3'h4,
    SEQ_DONE = 3'h5
  } scl_seq_t;

  // ----------------------------------------------------------------------
  // Trigger link word and main state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } scl_link_t;

  typedef struct packed {
    scl_seq_t seq;
    logic [23:0] wait_cnt;
    logic start_seen;
    logic [1:0] phase;
    logic [13:0] time_cnt;
    logic [3:0] frame_sh;
    logic [2:0] frame_left;
    logic line;
    logic [2:0] ones_cnt;
    scl_link_t pend;
    scl_link_t link;
    logic slot_strobe;
    logic trig_lost;
    logic accept;
    logic cmd_busy;
    logic start_sent;
    logic [4:0] tap;
  } scl_state_t;

  typedef struct packed {
    logic [1:0] pair;
  } scl_mch_t;

endpackage

// ==== core/scl_manchester.sv ====
/*
  Manchester encoder for the sync command line: one line bit per clock
  becomes a registered pair of half bits, first half in bit 1.
  Assumes a double data rate output cell shifts the pair out.
*/
`timescale 1ns/100ps
`include "scl_cfg.svh"

module scl_manchester (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Line bit
  input wire logic bit_in,
  // Encoded half bits
  output logic [1:0] pair_out
);

  scl_pkg::scl_mch_t st_reg;
  scl_pkg::scl_mch_t st_next;

  // A one is sent high then low, a zero low then high.
  always_comb begin
    st_next = st_reg;
    st_next.pair = {bit_in, ~bit_in};
  end

  // Register the pair; reset shows the idle level.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg.pair <= `SCL_PAIR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pair_out = st_reg.pair;

endmodule // scl_manchester

// ==== core/scl_top.sv ====
/*
  Sync command line encoder and trigger link start-up sequencer. Sends
  framed 4-bit commands one bit per clock, Manchester encoded, and
  steers the trigger link from idle words to trigger and time words.
  Assumes all inputs are synchronous to sys_clk and that an output
  delay cell applies sync_delay_tap to the line.
*/
`timescale 1ns/100ps
`include "scl_cfg.svh"

// Summary of operation
// - Line changes only on clock edges, one bit each cycle.
// - A user or trigger start command may start on any cycle once the line is free.
// - Frame is zero start bit, four bits LSB first, one stop bit.
// - Output delay tap in 80 ps steps, held from a static setting.
// - Line bits are Manchester encoded before leaving; far end decodes.
// - Until the trigger start request is taken, triggers refused and link sends idle words.
// - Once the start request is taken the link sends trigger or time words.
// - Trigger start command goes once after the programmed delay.
// - Clock phase reset sent at start-up aligned to the slot phase.
// - Clock phase reset precedes trigger start by at least the recovery gap.
// - One link word per 160 ns slot, trigger phase in 40 ns quarters.
// - Idle slots after start carry time counter bits 13 to 2.
module scl_top #(
  parameter int unsigned RECOVER_CYCLES = `SCL_RECOVER_CYCLES,
  parameter logic [3:0] CMD_CLK_RESET = `SCL_CMD_CLK_RESET,
  parameter logic [3:0] CMD_TRG_START = `SCL_CMD_TRG_START
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Start-up control
  input wire logic trg_start_req,
  input wire logic [15:0] start_delay,
  input wire logic [4:0] delay_tap_cfg,
  // Trigger input
  input wire logic trig_valid,
  input wire logic [9:0] trig_type,
  // Direct command request
  input wire logic user_cmd_valid,
  input wire logic [3:0] user_cmd_code,
  // Sync command line
  output logic [1:0] sync_pair,
  output logic [4:0] sync_delay_tap,
  output logic cmd_busy,
  output logic start_sent,
  // Trigger link
  output logic [15:0] link_word,
  output logic link_valid,
  output logic slot_strobe,
  output logic trig_accept_en,
  output logic trig_lost
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Data bits that follow the start bit, shifted out LSB first.
  function automatic logic [3:0] frame_rest(input logic [3:0] code);
    return code;
  endfunction

  // The line is free when no frame runs and enough idle ones have passed.
  function automatic logic line_free(input logic [2:0] left,
                                     input logic [2:0] ones);
    return (left == 3'h0) && (ones >= `SCL_IDLE_MIN);
  endfunction

  scl_pkg::scl_state_t st_reg;
  scl_pkg::scl_state_t st_next;
  logic [1:0] pair_w;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------

  // Sequencer, command framer and link word selection in one pass.
  always_comb begin
    logic free;
    logic launch;
    logic [3:0] code;
    logic running;
    logic take;
    logic slot;
    scl_pkg::scl_link_t eff;
    free = 1'h0;
    launch = 1'h0;
    code = 4'h0;
    running = 1'h0;
    take = 1'h0;
    slot = 1'h0;
    eff = st_reg.pend;
    st_next = st_reg;

    free = line_free(st_reg.frame_left, st_reg.ones_cnt);
    st_next.phase = st_reg.phase + 2'h1;
    st_next.time_cnt = st_reg.time_cnt + 14'h0001;
    st_next.slot_strobe = 1'h0;
    st_next.trig_lost = 1'h0;
    st_next.tap = delay_tap_cfg;

    // Trigger start requests are held until the sequencer can use them.
    if (trg_start_req) begin
      st_next.start_seen = 1'h1;
    end

    // Start-up sequence.
    case (st_reg.seq)
      scl_pkg::SEQ_BOOT: begin
        st_next.seq = scl_pkg::SEQ_PHASE;
      end
      scl_pkg::SEQ_PHASE: begin
        if (free && (st_reg.phase == `SCL_LAUNCH_PHASE)) begin
          launch = 1'h1;
          code = CMD_CLK_RESET;
          st_next.seq = scl_pkg::SEQ_RECOVER;
          st_next.wait_cnt = 24'(RECOVER_CYCLES - 1);
        end
      end
      scl_pkg::SEQ_RECOVER: begin
        if (st_reg.wait_cnt == 24'h000000) begin
          st_next.seq = scl_pkg::SEQ_ARMED;
        end else begin
          st_next.wait_cnt = st_reg.wait_cnt - 24'h000001;
        end
      end
      scl_pkg::SEQ_ARMED: begin
        if (st_reg.start_seen || trg_start_req) begin
          st_next.seq = scl_pkg::SEQ_DELAY;
          st_next.wait_cnt = {8'h00, start_delay};
        end
      end
      scl_pkg::SEQ_DELAY: begin
        if ((st_reg.wait_cnt == 24'h000000) && free) begin
          launch = 1'h1;
          code = CMD_TRG_START;
          st_next.seq = scl_pkg::SEQ_DONE;
          st_next.start_sent = 1'h1;
        end else if (st_reg.wait_cnt != 24'h000000) begin
          st_next.wait_cnt = st_reg.wait_cnt - 24'h000001;
        end
      end
      scl_pkg::SEQ_DONE: begin
        st_next.seq = scl_pkg::SEQ_DONE;
      end
      default: begin
        st_next.seq = scl_pkg::SEQ_BOOT;
      end
    endcase

    if (!launch && free && user_cmd_valid) begin
      launch = 1'h1;
      code = user_cmd_code;
    end

    // Frame shifter: start bit now, then data bits and the stop bit.
    if (launch) begin
      st_next.line = 1'h0;
      st_next.frame_sh = frame_rest(code);
      st_next.frame_left = `SCL_FRAME_REST;
    end else if (st_reg.frame_left > 3'h1) begin
      st_next.line = st_reg.frame_sh[0];
      st_next.frame_sh = {1'h0, st_reg.frame_sh[3:1]};
      st_next.frame_left = st_reg.frame_left - 3'h1;
    end else if (st_reg.frame_left == 3'h1) begin
      st_next.line = `SCL_LINE_IDLE;
      st_next.frame_left = 3'h0;
      st_next.ones_cnt = 3'h0;
    end else begin
      st_next.line = `SCL_LINE_IDLE;
      if (st_reg.ones_cnt != `SCL_ONES_SAT) begin
        st_next.ones_cnt = st_reg.ones_cnt + 3'h1;
      end
    end
    st_next.cmd_busy = (st_next.frame_left != 3'h0) ||
                       (st_next.ones_cnt < `SCL_IDLE_MIN);

    running = (st_reg.seq == scl_pkg::SEQ_DELAY) ||
              (st_reg.seq == scl_pkg::SEQ_DONE);
    st_next.accept = (st_next.seq == scl_pkg::SEQ_DELAY) ||
                     (st_next.seq == scl_pkg::SEQ_DONE);
    slot = (st_reg.phase == `SCL_SLOT_LAST);

    if (st_reg.accept && trig_valid) begin
      if (st_reg.pend.valid) begin
        st_next.trig_lost = 1'h1;
      end else begin
        take = 1'h1;
        eff.valid = 1'h1;
        eff.word = {`SCL_WORD_STROBE, st_reg.phase, trig_type};
      end
    end
    st_next.pend = eff;

    // One word per slot; a pending strobe wins over the time word.
    if (slot) begin
      st_next.slot_strobe = 1'h1;
      if (!running) begin
        st_next.link.valid = 1'h0;
        st_next.link.word = `SCL_IDLE_WORD;
      end else if (eff.valid) begin
        st_next.link = eff;
        st_next.pend.valid = 1'h0;
      end else begin
        st_next.link.valid = 1'h1;
        st_next.link.word = {`SCL_WORD_TIME,
          st_reg.time_cnt[`SCL_TIME_HI:`SCL_TIME_LO]};
      end
    end
    if (take && !slot) begin
      st_next.pend = eff;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Reset leaves the line idle, the link silent and triggers refused.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg.seq <= scl_pkg::SEQ_BOOT;
      st_reg.wait_cnt <= 24'h000000;
      st_reg.start_seen <= 1'h0;
      st_reg.phase <= 2'h0;
      st_reg.time_cnt <= 14'h0000;
      st_reg.frame_sh <= 4'h0;
      st_reg.frame_left <= 3'h0;
      st_reg.line <= `SCL_LINE_IDLE;
      st_reg.ones_cnt <= `SCL_ONES_SAT;
      st_reg.pend <= '0;
      st_reg.link <= '0;
      st_reg.slot_strobe <= 1'h0;
      st_reg.trig_lost <= 1'h0;
      st_reg.accept <= 1'h0;
      st_reg.cmd_busy <= 1'h0;
      st_reg.start_sent <= 1'h0;
      st_reg.tap <= 5'h00;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Line encoder and outputs
  // ----------------------------------------------------------------------

  scl_manchester u_mch (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bit_in(st_reg.line),
    .pair_out(pair_w)
  );

  // All outputs are flip-flop outputs.
  assign sync_pair = pair_w;
  assign sync_delay_tap = st_reg.tap;
  assign cmd_busy = st_reg.cmd_busy;
  assign start_sent = st_reg.start_sent;
  assign link_word = st_reg.link.word;
  assign link_valid = st_reg.link.valid;
  assign slot_strobe = st_reg.slot_strobe;
  assign trig_accept_en = st_reg.accept;
  assign trig_lost = st_reg.trig_lost;

endmodule // scl_top

// ==== tb/scl_top_properties.sv ====
/*
  Port checker for scl_top: line framing, start-up order and link slots.
  Assumes a bind from the bench top and one clock domain.
*/
`timescale 1ns/100ps

module scl_top_properties #(
  parameter int unsigned RECOVER_CYCLES = 20,
  parameter logic [3:0] CMD_CLK_RESET = 4'h1,
  parameter logic [3:0] CMD_TRG_START = 4'h2
) (
  // Clock, reset and inputs
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic trg_start_req,
  input wire logic [15:0] start_delay,
  input wire logic [4:0] delay_tap_cfg,
  input wire logic trig_valid,
  input wire logic [9:0] trig_type,
  input wire logic user_cmd_valid,
  input wire logic [3:0] user_cmd_code,
  // Outputs of the design
  input wire logic [1:0] sync_pair,
  input wire logic [4:0] sync_delay_tap,
  input wire logic cmd_busy,
  input wire logic start_sent,
  input wire logic [15:0] link_word,
  input wire logic link_valid,
  input wire logic slot_strobe,
  input wire logic trig_accept_en,
  input wire logic trig_lost
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // Five idle ones and then a start bit on the encoded line.
  sequence idle_start;
    (sync_pair == 2'h2) [*5] ##1 sync_pair == 2'h1;
  endsequence

  // Four code bits least significant first, then the stop bit.
  sequence cmd_frame(logic [3:0] c);
    sync_pair == {c[0], !c[0]} ##1 sync_pair == {c[1], !c[1]} ##1
    sync_pair == {c[2], !c[2]} ##1 sync_pair == {c[3], !c[3]} ##1
    sync_pair == 2'h2;
  endsequence

  chk_pair_balance: assert property (sync_pair[1] != sync_pair[0])
    else $error("sync pair halves equal");
  chk_tap_follow: assert property ($past(rst_n) |->
    sync_delay_tap == $past(delay_tap_cfg))
    else $error("delay tap does not follow setting");
  chk_idle_gap: assert property (idle_start |->
    ##5 (sync_pair == 2'h2) [*6])
    else $error("stop bit or idle ones missing");
  chk_trg_frame: assert property ($rose(start_sent) |=>
    sync_pair == 2'h1 ##1 cmd_frame(CMD_TRG_START))
    else $error("trigger start frame wrong");
  // The first frame follows reset after only four idle samples, so the
  // antecedent starts at the start pair itself.
  chk_phase_align: assert property (sync_pair == 2'h1 ##1
    cmd_frame(CMD_CLK_RESET) ##0 !trig_accept_en |-> $past(slot_strobe, 5))
    else $error("clock reset not slot aligned");
  chk_idle_link: assert property (!trig_accept_en |->
    !link_valid && link_word == 16'h0)
    else $error("link not idle before start");
  chk_link_start: assert property ($rose(trig_accept_en) |->
    ##[0:4] (slot_strobe && link_valid))
    else $error("link words did not begin");
  chk_slot_period: assert property (slot_strobe |=>
    !slot_strobe [*3] ##1 slot_strobe)
    else $error("slot strobe period wrong");
  chk_time_step: assert property ((slot_strobe &&
    link_word[15:12] == 4'h4) ##4 (link_word[15:12] == 4'h4) |->
    link_word[11:0] == 12'($past(link_word, 4) + 16'h1))
    else $error("time word did not advance");
endmodule // scl_top_properties

// ==== tb/scl_rx_model.sv ====
/*
  Far-end model: Manchester decode and command frame receiver with a
  trigger FIFO write count and read enable. Assumes sys_clk is shared.
*/
`timescale 1ns/100ps

module scl_rx_model #(
  // command codes agreed with the encoder.
  parameter logic [3:0] CMD_CLK_RESET = 4'h1,
  parameter logic [3:0] CMD_TRG_START = 4'h2
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Encoded line and trigger link
  input wire logic [1:0] sync_pair,
  input wire logic link_valid,
  input wire logic slot_strobe,
  // Decoded commands
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic frame_err,
  output logic fifo_rd_en,
  output logic [7:0] fifo_wr_cnt,
  output logic [7:0] fifo_rd_cnt,
  output logic [1:0] div_phase
);
  // --------------------
  // Receiver
  // --------------------
  logic [2:0] ones = 3'h0;
  logic [2:0] cnt;
  logic busy;
  logic b;
  logic act_v1, act_v2;
  logic [3:0] act_c1, act_c2;

  // first half bit carries the line bit.
  assign b = sync_pair[1];

  // idle ones counted, also while reset holds the line high.
  always @(posedge sys_clk) begin
    if (busy || !b) ones <= 3'h0;
    else if (ones != 3'h7) ones <= ones + 3'h1;
  end

  // Frame receiver and FIFO bookkeeping, one sample per clock.
  always @(posedge sys_clk) begin
    cmd_valid <= 1'b0;
    if (!rst_n) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      frame_err <= 1'b0;
      fifo_rd_en <= 1'b0;
      fifo_wr_cnt <= 8'h0;
      fifo_rd_cnt <= 8'h0;
      act_v1 <= 1'b0;
      act_v2 <= 1'b0;
      // Divider starts out of step until a clock reset arrives.
      div_phase <= 2'h1;
    end else begin
      frame_err <= frame_err | (sync_pair[0] == b);
      if (slot_strobe && link_valid) fifo_wr_cnt <= fifo_wr_cnt + 8'h1;
      // decoded commands wait out a fixed two-cycle fibre latency.
      act_v1 <= 1'b0;
      act_v2 <= act_v1;
      act_c2 <= act_c1;
      // clock reset restarts the divider on one clock edge.
      if (act_v2 && act_c2 == CMD_CLK_RESET) div_phase <= 2'h0;
      else div_phase <= div_phase + 2'h1;
      if (act_v2 && act_c2 == CMD_TRG_START) fifo_rd_en <= 1'b1;
      // one read per divided clock period once reading is enabled.
      if (fifo_rd_en && div_phase == 2'h3) begin
        fifo_rd_cnt <= fifo_rd_cnt + 8'h1;
      end
      // start bit after more than four ones, then bits and stop.
      if (!busy) begin
        busy <= !b && ones > 3'h4;
      end else if (cnt != 3'h4) begin
        cmd_code <= {b, cmd_code[3:1]};
        cnt <= cnt + 3'h1;
      end else begin
        busy <= 1'b0;
        cnt <= 3'h0;
        cmd_valid <= 1'b1;
        frame_err <= frame_err | !b;
        act_v1 <= 1'b1;
        act_c1 <= cmd_code;
      end
    end
  end
endmodule // scl_rx_model

// ==== tb/scl_top_tb_top.sv ====
/*
  Bench top for scl_top: start-up order, trigger link and user commands
  against the far-end model. Assumes the checker is bound below.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end

module scl_top_tb_top;
  // --------------------
  // Signals and design
  // --------------------
  localparam int unsigned REC = 20;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic trg_start_req = 1'b0;
  logic [15:0] start_delay = 16'h0;
  logic [4:0] delay_tap_cfg = 5'h0;
  logic trig_valid = 1'b0;
  logic [9:0] trig_type = 10'h0;
  logic user_cmd_valid = 1'b0;
  logic [3:0] user_cmd_code = 4'h0;
  logic [1:0] sync_pair;
  logic [4:0] sync_delay_tap;
  logic cmd_busy, start_sent, link_valid, slot_strobe;
  logic trig_accept_en, trig_lost, rx_valid, rx_err, rx_rd;
  logic [15:0] link_word, w0;
  logic [3:0] rx_code, c, rx_code_seen;
  logic [1:0] rx_div;
  logic [7:0] rx_wr, rx_rdc, lvl;
  logic [9:0] t;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int t_acc = 0;
  int t0, q, i;

  scl_top #(.RECOVER_CYCLES(REC)) u_scl_top (.sys_clk, .rst_n,
    .trg_start_req, .start_delay, .delay_tap_cfg, .trig_valid, .trig_type,
    .user_cmd_valid, .user_cmd_code, .sync_pair, .sync_delay_tap,
    .cmd_busy, .start_sent, .link_word, .link_valid, .slot_strobe,
    .trig_accept_en, .trig_lost);

  scl_rx_model u_scl_rx_model (.sys_clk, .rst_n, .sync_pair, .link_valid,
    .slot_strobe, .cmd_valid(rx_valid), .cmd_code(rx_code),
    .frame_err(rx_err), .fifo_rd_en(rx_rd), .fifo_wr_cnt(rx_wr),
    .fifo_rd_cnt(rx_rdc), .div_phase(rx_div));

  // Clock of 40 ns period.
  initial forever #20 sys_clk = ~sys_clk;

  // Cycle count, acceptance time stamp and hang limit.
  always @(posedge sys_clk) begin
    cyc++;
    if (trig_accept_en === 1'b1 && t_acc == 0) t_acc = cyc;
    if (cyc == 4000) begin
      bad_count++;
      stop_test();
    end
  end

  // Inputs change 1 ns after the rising edge.
  task automatic step(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_slot();
    for (int k = 0; k < 8 && slot_strobe !== 1'b1; k++) step(1);
  endtask

  task automatic wait_rx(output logic [3:0] code);
    for (int k = 0; k < 400 && rx_valid !== 1'b1; k++) step(1);
    code = rx_code;
  endtask

  task automatic stop_test();
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Expected trigger strobe word from its quarter and trigger bits.
  function automatic logic [15:0] exp_strobe(input logic [1:0] qt,
                                             input logic [9:0] ty);
    return {4'h9, qt, ty};
  endfunction

  // Main sequence: start-up, trigger slots, then user commands.
  initial begin
    void'($urandom(36));
    delay_tap_cfg = 5'($urandom);
    trig_valid = 1'b1;
    trig_type = 10'($urandom);
    step(20);
    rst_n = 1'b1;
    wait_rx(c);
    t0 = cyc;
    `CHK("first cmd", 4'h1, c)
    `CHK("idle link", 1'b0, link_valid)
    `CHK("tap", delay_tap_cfg, sync_delay_tap)
    `CHK("fifo empty", 8'h00, rx_wr)
    trig_valid = 1'b0;
    start_delay = 16'h8 + 16'($urandom_range(7));
    trg_start_req = 1'b1;
    step(1);
    trg_start_req = 1'b0;
    wait_rx(c);
    `CHK("second cmd", 4'h2, c)
    `CHK("gap", 1'b1, (cyc - t0 >= REC))
    `CHK("delay", 1'b1, (cyc - t_acc >= int'(start_delay)))
    `CHK("start sent", 1'b1, start_sent)
    step(2);
    `CHK("fifo read", 1'b1, rx_rd)
    `CHK("link valid", 1'b1, link_valid)
    wait_slot();
    lvl = 8'(rx_wr - rx_rdc);
    for (q = 0; q < 4; q++) begin
      t = 10'($urandom);
      wait_slot();
      repeat (q) step(1);
      trig_valid = 1'b1;
      trig_type = t;
      step(1);
      trig_valid = 1'b0;
      wait_slot();
      `CHK("strobe word", exp_strobe(2'(q), t), link_word)
      `CHK("divider", 2'h0, rx_div)
    end
    step(1);
    wait_slot();
    w0 = link_word;
    step(1);
    wait_slot();
    `CHK("time word", {4'h4, 12'(w0[11:0] + 12'h1)}, link_word)
    `CHK("fifo level", lvl, 8'(rx_wr - rx_rdc))
    trig_valid = 1'b1;
    step(2);
    trig_valid = 1'b0;
    `CHK("lost", 1'b1, trig_lost)
    for (i = 0; i < 8; i++) begin
      c = (i < 2) ? {4{i[0]}} : 4'($urandom);
      user_cmd_code = c;
      user_cmd_valid = 1'b1;
      step(1);
      `CHK("busy", 1'b1, cmd_busy)
      user_cmd_code = ~c;
      step(1);
      user_cmd_valid = 1'b0;
      wait_rx(rx_code_seen);
      `CHK("user cmd", c, rx_code_seen)
      for (int k = 0; k < 20 && cmd_busy !== 1'b0; k++) step(1);
      repeat ($urandom_range(3)) step(1);
    end
    `CHK("frame error", 1'b0, rx_err)
    stop_test();
  end
endmodule // scl_top_tb_top

bind scl_top scl_top_properties #(.RECOVER_CYCLES(RECOVER_CYCLES),
  .CMD_CLK_RESET(CMD_CLK_RESET), .CMD_TRG_START(CMD_TRG_START)) u_chk (
  .sys_clk, .rst_n, .trg_start_req, .start_delay, .delay_tap_cfg,
  .trig_valid, .trig_type, .user_cmd_valid, .user_cmd_code, .sync_pair,
  .sync_delay_tap, .cmd_busy, .start_sent, .link_word, .link_valid,
  .slot_strobe, .trig_accept_en, .trig_lost);
